// ### ass_adc_model.sv
// adc macro model: answers each start pulse with a done pulse
// assumes: one clock, sync active-high reset
`timescale 1ns/10ps
module ass_adc_model #(
  parameter int LAT = 4
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic adc_convert,
  output logic adc_clk_en,
  output logic adc_conv_done
);
  logic [7:0] cnt_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q <= 8'h00;
      adc_clk_en <= 1'b0;
      adc_conv_done <= 1'b0;
    end else begin
      adc_clk_en <= 1'b1;
      adc_conv_done <= (cnt_q == 8'h01);
      if (adc_convert) cnt_q <= 8'(LAT);
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : ass_adc_model

// ### ass_pkg.sv
// package: constants and types for the slot sequencer
// assumes: used with ass_slot_sequencer, one 25 MHz clock
package ass_pkg;
  localparam int SLOT_COUNT = 64;
  localparam int SLOT_W = 6;
  localparam int CHAN_W = 5;
  localparam int OP_W = 3;
  localparam int ENTRY_W = OP_W + CHAN_W + SLOT_W;
  // entry field positions
  localparam int DEST_LSB = 0;
  localparam int CHAN_LSB = SLOT_W;
  localparam int OP_LSB = SLOT_W + CHAN_W;
  localparam logic [SLOT_W-1:0] RESET_SLOT = 6'h00;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 6'h3F;
  // calibration lasts this many adc clock periods
  localparam int TRIM_ADC_CLOCKS = 3840;
  localparam logic [11:0] TRIM_COUNT = 12'(TRIM_ADC_CLOCKS - 1);
  localparam logic [ENTRY_W-1:0] ENTRY_RESET = 14'h0000;
  typedef enum logic [OP_W-1:0] {
    ASS_IDLE_OP = 3'h0,
    ASS_CONVERT_OP = 3'h1,
    ASS_CONVERT_BRANCH_OP = 3'h2,
    ASS_TRIM_OP = 3'h3,
    ASS_TRIM_BRANCH_OP = 3'h4,
    ASS_BRANCH_OP = 3'h5,
    ASS_SLEEP_OP = 3'h6,
    ASS_HALT_OP = 3'h7
  } ass_op_t;
endpackage : ass_pkg

// ### ass_slot_sequencer.sv
// file: slot table sequencer driving one adc
// assumes: adc macro gives one-cycle done pulses; adc_clk_en is one pulse per adc clock
`timescale 1ns/10ps
// Summary of operation
// - one table of 64 slots holds every procedure.
// - slots can hold calibration and powerdown as well as conversions.
// - adc converts channels in table order, looping with the sequence.
// - after reset execution starts at slot 0, the default procedure.
// - jump and trigger ports are always present but take effect only with more than one procedure.
// - convert_op converts its channel then steps to the next slot.
// - convert_branch_op converts then continues at its destination slot.
// - trim_op calibrates for 3840 adc clocks then steps on.
// - trim_branch_op calibrates then continues at its destination slot.
// - branch_op jumps straight to its destination without converting.
// - sleep_op powers down; no conversion until calibration runs again.
// - halt_op stops the sequencer until an outside trigger restarts it.
// - idle_op does nothing, uses a slot, steps to next.
// - slot_branch_req moves to slot_target_in after current slot finishes.
// - slot_complete marks the end of processing of the current slot.
// - in manual mode a one-cycle manual_step_pulse starts processing of the next slot.
// - automatic forwarding wraps from slot 63 to slot 0.
module ass_slot_sequencer #(
  parameter bit MULTI_PROC = 1'b1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic tbl_wr_en,
  input wire logic [ass_pkg::SLOT_W-1:0] tbl_wr_addr,
  input wire logic [ass_pkg::ENTRY_W-1:0] tbl_wr_data,
  input wire logic adc_clk_en,
  input wire logic adc_conv_done,
  input wire logic slot_branch_req,
  input wire logic [ass_pkg::SLOT_W-1:0] slot_target_in,
  input wire logic manual_step_sel,
  input wire logic manual_step_pulse,
  output logic adc_convert,
  output logic [ass_pkg::CHAN_W-1:0] adc_channel,
  output logic adc_calibrate,
  output logic adc_powerdown,
  output logic slot_complete,
  output logic [ass_pkg::SLOT_W-1:0] slot_current,
  output logic sequencer_halted
);
  // ****************************************
  // slot table and decode
  // ****************************************
  typedef enum logic [2:0] {ASS_FETCH, ASS_WAIT_STEP, ASS_CONV, ASS_TRIM, ASS_STOPPED} ass_state_t;
  logic [ass_pkg::ENTRY_W-1:0] table_q [ass_pkg::SLOT_COUNT];
  ass_state_t state_q;
  logic [ass_pkg::SLOT_W-1:0] slot_q;
  logic [11:0] trim_cnt_q;
  logic slept_q;
  logic [ass_pkg::ENTRY_W-1:0] entry;
  ass_pkg::ass_op_t op;
  logic [ass_pkg::SLOT_W-1:0] dest;
  logic [ass_pkg::CHAN_W-1:0] chan;
  assign entry = table_q[slot_q];
  assign op = ass_pkg::ass_op_t'(entry[ass_pkg::OP_LSB +: ass_pkg::OP_W]);
  assign dest = entry[ass_pkg::DEST_LSB +: ass_pkg::SLOT_W];
  assign chan = entry[ass_pkg::CHAN_LSB +: ass_pkg::CHAN_W];
  // ports are ignored when one procedure is built
  wire jump_req = MULTI_PROC && slot_branch_req;
  wire manual = MULTI_PROC && manual_step_sel;
  wire step = MULTI_PROC && manual_step_pulse;
  wire is_branch = (op == ass_pkg::ASS_CONVERT_BRANCH_OP) || (op == ass_pkg::ASS_TRIM_BRANCH_OP) ||
                   (op == ass_pkg::ASS_BRANCH_OP);
  // next slot: outside jump wins, then the entry's branch, then step with wrap
  wire [ass_pkg::SLOT_W-1:0] seq_next = jump_req ? slot_target_in :
                                        is_branch ? dest :
                                        (slot_q + 6'h01);
  wire conv_fin = (state_q == ass_state_t'(ASS_CONV)) && adc_conv_done;
  wire trim_fin = (state_q == ass_state_t'(ASS_TRIM)) && adc_clk_en && (trim_cnt_q == ass_pkg::TRIM_COUNT);
  wire quick_op = (op == ass_pkg::ASS_IDLE_OP) || (op == ass_pkg::ASS_BRANCH_OP);
  // a convert after sleep is skipped until calibration
  wire conv_blocked = slept_q && ((op == ass_pkg::ASS_CONVERT_OP) || (op == ass_pkg::ASS_CONVERT_BRANCH_OP));
  wire fetch_fin = (state_q == ass_state_t'(ASS_FETCH)) && (quick_op || conv_blocked);
  wire slot_fin = conv_fin || trim_fin || fetch_fin;
  wire can_start = !manual || step;
  // ****************************************
  // table write port
  // ****************************************
  always_ff @(posedge clock) begin
    if (tbl_wr_en) begin
      table_q[tbl_wr_addr] <= tbl_wr_data;
    end
  end
  // ****************************************
  // sequencing state machine
  // ****************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= ASS_FETCH;
      slot_q <= ass_pkg::RESET_SLOT;
      trim_cnt_q <= 12'h000;
      slept_q <= 1'b0;
    end else begin
      case (state_q)
        ASS_WAIT_STEP: begin
          if (jump_req) begin
            slot_q <= slot_target_in;
            state_q <= ASS_FETCH;
          end else if (can_start) begin
            state_q <= ASS_FETCH;
          end
        end
        ASS_FETCH: begin
          if (fetch_fin) begin
            slot_q <= seq_next;
            state_q <= manual ? ASS_WAIT_STEP : ASS_FETCH;
          end else begin
            case (op)
              ass_pkg::ASS_CONVERT_OP, ass_pkg::ASS_CONVERT_BRANCH_OP: state_q <= ASS_CONV;
              ass_pkg::ASS_TRIM_OP, ass_pkg::ASS_TRIM_BRANCH_OP: begin
                trim_cnt_q <= 12'h000;
                state_q <= ASS_TRIM;
              end
              ass_pkg::ASS_SLEEP_OP: begin
                slept_q <= 1'b1;
                state_q <= ASS_STOPPED;
              end
              ass_pkg::ASS_HALT_OP: state_q <= ASS_STOPPED;
              default: state_q <= ASS_FETCH;
            endcase
          end
        end
        ASS_CONV, ASS_TRIM: begin
          if (state_q == ASS_TRIM && adc_clk_en) begin
            trim_cnt_q <= trim_cnt_q + 12'h001;
          end
          if (trim_fin) begin
            slept_q <= 1'b0;
          end
          if (slot_fin) begin
            slot_q <= seq_next;
            state_q <= manual ? ASS_WAIT_STEP : ASS_FETCH;
          end
        end
        ASS_STOPPED: begin
          // only an outside jump restarts after halt or sleep
          if (jump_req) begin
            slot_q <= slot_target_in;
            state_q <= ASS_FETCH;
          end
        end
        default: state_q <= ASS_FETCH;
      endcase
    end
  end
  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      adc_convert <= 1'b0;
      adc_channel <= 5'h00;
      adc_calibrate <= 1'b0;
      adc_powerdown <= 1'b0;
      slot_complete <= 1'b0;
      slot_current <= ass_pkg::RESET_SLOT;
      sequencer_halted <= 1'b0;
    end else begin
      adc_convert <= (state_q == ASS_FETCH) && !conv_blocked &&
                     ((op == ass_pkg::ASS_CONVERT_OP) || (op == ass_pkg::ASS_CONVERT_BRANCH_OP));
      adc_channel <= chan;
      adc_calibrate <= (state_q == ASS_TRIM) && !trim_fin;
      adc_powerdown <= slept_q;
      slot_complete <= slot_fin;
      slot_current <= slot_q;
      sequencer_halted <= (state_q == ASS_STOPPED);
    end
  end
  // ****************************************
  // checks
  // ****************************************
  // ****************************************
  // helper for checks
  // ****************************************
  logic [11:0] trim_seen_q;
  always_ff @(posedge clock) begin
    if (sys_rst || state_q != ASS_TRIM) begin
      trim_seen_q <= 12'h000;
    end else if (adc_clk_en) begin
      trim_seen_q <= trim_seen_q + 12'h001;
    end
  end
  property done_follows_p;
    @(posedge clock) disable iff (sys_rst) slot_fin |=> slot_complete;
  endproperty
  slot_done_a: assert property (done_follows_p) else $error("slot_complete missing");
  reset_slot_a: assert property (@(posedge clock) $fell(sys_rst) |-> slot_q == ass_pkg::RESET_SLOT)
    else $error("not at slot 0 after reset");
  wrap_slot_a: assert property (@(posedge clock) disable iff (sys_rst)
    (slot_fin && !jump_req && !is_branch && slot_q == ass_pkg::LAST_SLOT) |=> slot_q == ass_pkg::RESET_SLOT)
    else $error("no wrap to slot 0");
  branch_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    (slot_fin && !jump_req && is_branch) |=> slot_q == $past(dest))
    else $error("branch destination not loaded");
  jump_load_a: assert property (@(posedge clock) disable iff (sys_rst)
    (slot_fin && jump_req) |=> slot_q == $past(slot_target_in))
    else $error("outside jump not taken");
  halt_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ASS_STOPPED && !jump_req) |=> state_q == ASS_STOPPED)
    else $error("halt left without trigger");
  sleep_conv_a: assert property (@(posedge clock) disable iff (sys_rst)
    slept_q |=> !adc_convert) else $error("convert after sleep");
  manual_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ASS_WAIT_STEP && manual && !step && !jump_req) |=> state_q == ASS_WAIT_STEP)
    else $error("manual step without pulse");
  trim_len_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ASS_TRIM && adc_clk_en) |-> (trim_fin == (trim_seen_q == ass_pkg::TRIM_COUNT)))
    else $error("trim length wrong");
  trim_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ASS_TRIM && !trim_fin) |=> state_q == ASS_TRIM)
    else $error("trim left early");
  calib_out_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ASS_TRIM && !trim_fin) |=> adc_calibrate)
    else $error("calibrate not shown");
  conv_pulse_a: assert property (@(posedge clock) disable iff (sys_rst) adc_convert |=> !adc_convert)
    else $error("convert pulse too long");
  halted_out_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ASS_STOPPED) |=> sequencer_halted) else $error("halt not shown");
  step_go_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_q == ASS_WAIT_STEP && step && !jump_req) |=> state_q == ASS_FETCH)
    else $error("step pulse ignored");
endmodule : ass_slot_sequencer

// ### ass_slot_sequencer_tb.sv
// testbench: slot sequencer against the adc model
// assumes: table loaded during reset
`timescale 1ns/10ps
module ass_slot_sequencer_tb;
  logic clock = 0, sys_rst = 1, tbl_wr_en = 0, adc_clk_en, adc_conv_done, slot_branch_req = 0;
  logic manual_step_sel = 0, manual_step_pulse = 0, adc_convert, adc_calibrate, adc_powerdown;
  logic slot_complete, sequencer_halted;
  logic [5:0] tbl_wr_addr = 6'h00, slot_target_in = 6'h00, slot_current, tgt;
  logic [13:0] tbl_wr_data = 14'h0000;
  logic [4:0] adc_channel;
  logic alt_convert, alt_clk_en, alt_done, alt_halted;
  int fails = 0, checked = 0, n, cnt;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
  always #20 clock = ~clock;
  ass_slot_sequencer i_dut (.clock(clock), .sys_rst(sys_rst), .tbl_wr_en(tbl_wr_en), .tbl_wr_addr(tbl_wr_addr),
    .tbl_wr_data(tbl_wr_data), .adc_clk_en(adc_clk_en), .adc_conv_done(adc_conv_done),
    .slot_branch_req(slot_branch_req), .slot_target_in(slot_target_in), .manual_step_sel(manual_step_sel),
    .manual_step_pulse(manual_step_pulse), .adc_convert(adc_convert), .adc_channel(adc_channel),
    .adc_calibrate(adc_calibrate), .adc_powerdown(adc_powerdown), .slot_complete(slot_complete),
    .slot_current(slot_current), .sequencer_halted(sequencer_halted));
  ass_adc_model #(.LAT(6)) i_adc (.clock(clock), .sys_rst(sys_rst), .adc_convert(adc_convert),
    .adc_clk_en(adc_clk_en), .adc_conv_done(adc_conv_done));
  // single-procedure build: jump and manual inputs must have no effect
  ass_slot_sequencer #(.MULTI_PROC(1'b0)) i_dut_single (.clock(clock), .sys_rst(sys_rst), .tbl_wr_en(tbl_wr_en),
    .tbl_wr_addr(tbl_wr_addr), .tbl_wr_data(tbl_wr_data), .adc_clk_en(alt_clk_en), .adc_conv_done(alt_done),
    .slot_branch_req(slot_branch_req), .slot_target_in(slot_target_in), .manual_step_sel(manual_step_sel),
    .manual_step_pulse(manual_step_pulse), .adc_convert(alt_convert), .adc_channel(), .adc_calibrate(),
    .adc_powerdown(), .slot_complete(), .slot_current(), .sequencer_halted(alt_halted));
  ass_adc_model #(.LAT(6)) i_adc_single (.clock(clock), .sys_rst(sys_rst), .adc_convert(alt_convert),
    .adc_clk_en(alt_clk_en), .adc_conv_done(alt_done));
  // ****************
  // tasks
  // ****************
  task automatic tick;
    @(posedge clock);
    #1;
  endtask : tick
  function automatic logic sig(input int w);
    case (w)
      0: return adc_convert;
      1: return slot_complete;
      2: return sequencer_halted;
      default: return slot_current === tgt;
    endcase
  endfunction : sig
  task automatic wait_hi(input int w, input int lim);
    n = 0;
    while (sig(w) !== 1'b1 && n < lim) begin
      tick;
      n++;
    end
    `CHK(sig(w), 1'b1)
  endtask : wait_hi
  task automatic wr(input logic [5:0] a, input logic [13:0] d);
    tbl_wr_addr = a;
    tbl_wr_data = d;
    tbl_wr_en = 1'b1;
    tick;
    tbl_wr_en = 1'b0;
  endtask : wr
  task automatic jump(input logic [5:0] t);
    tgt = t;
    slot_target_in = t;
    slot_branch_req = 1'b1;
    wait_hi(3, 400);
    slot_branch_req = 1'b0;
  endtask : jump
  task automatic conv(input logic [4:0] ch);
    wait_hi(0, 400);
    `CHK(adc_channel, ch)
    tick;
  endtask : conv
  task automatic quiet(input int len);
    cnt = 0;
    repeat (len) begin
      if (adc_convert === 1'b1 || slot_complete === 1'b1) cnt++;
      tick;
    end
  endtask : quiet
  task automatic trim_check(input logic [4:0] ch);
    cnt = 0;
    n = 0;
    while (adc_calibrate !== 1'b1 && n < 100) begin
      if (adc_convert === 1'b1) cnt++;
      tick;
      n++;
    end
    `CHK(cnt, 0)
    `CHK(adc_calibrate, 1'b1)
    n = 0;
    while (adc_calibrate === 1'b1 && n < 5000) begin
      tick;
      n++;
    end
    `CHK(n >= 3838 && n <= 3842, 1'b1)
    conv(ch);
  endtask : trim_check
  task automatic report_and_stop;
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    report_and_stop;
  end
  task automatic load_table;
    wr(6'h00, 14'h08C0);
    wr(6'h01, 14'h1144);
    wr(6'h04, 14'h0000);
    wr(6'h05, 14'h2800);
    wr(6'h0A, 14'h3800);
    wr(6'h14, 14'h3000);
    wr(6'h15, 14'h09C0);
    wr(6'h16, 14'h1800);
    wr(6'h17, 14'h1240);
    wr(6'h3F, 14'h0880);
    wr(6'h20, 14'h203F);
    `CHK(slot_current, 6'h00)
    sys_rst = 1'b0;
  endtask : load_table
  task automatic auto_run;
    conv(5'h03);
    conv(5'h05);
    wait_hi(1, 100);
    conv(5'h03);
    jump(6'h3F);
    conv(5'h02);
    conv(5'h03);
  endtask : auto_run
  task automatic halt_run;
    jump(6'h0A);
    wait_hi(2, 50);
    `CHK(alt_halted, 1'b0)
    quiet(30);
    `CHK(cnt, 0)
    jump(6'h00);
    conv(5'h03);
  endtask : halt_run
  task automatic sleep_run;
    jump(6'h14);
    wait_hi(2, 50);
    `CHK(adc_powerdown, 1'b1)
    jump(6'h15);
    trim_check(5'h09);
    `CHK(adc_powerdown, 1'b0)
    jump(6'h20);
    trim_check(5'h02);
  endtask : sleep_run
  task automatic manual_run;
    manual_step_sel = 1'b1;
    wait_hi(1, 300);
    tick;
    quiet(40);
    `CHK(cnt, 0)
    `CHK(slot_current, 6'h00)
    manual_step_pulse = 1'b1;
    tick;
    manual_step_pulse = 1'b0;
    conv(5'h03);
    wait_hi(1, 300);
    manual_step_sel = 1'b0;
  endtask : manual_run
  initial begin
    #1;
    load_table;
    auto_run;
    halt_run;
    sleep_run;
    manual_run;
    report_and_stop;
  end
endmodule : ass_slot_sequencer_tb
